// ==== dtc_pkg.sv ====
// constants for the dual timer/counter block
package dtc_pkg;
  localparam logic [7:0] RUN_CTRL_ADDR  = 8'h88;  // run/flag register address
  localparam logic [7:0] MODE_CTRL_ADDR = 8'h89;  // mode register address
  localparam logic [7:0] LOW_A_ADDR     = 8'h8a;  // low count byte, timer a
  localparam logic [7:0] LOW_B_ADDR     = 8'h8b;  // low count byte, timer b
  localparam logic [7:0] HIGH_A_ADDR    = 8'h8c;  // high count byte, timer a
  localparam logic [7:0] HIGH_B_ADDR    = 8'h8d;  // high count byte, timer b
  localparam logic [7:0] RUN_CTRL_RST   = 8'h00;  // run register reset value
  localparam logic [7:0] MODE_CTRL_RST  = 8'h00;  // mode register reset value
  localparam logic [7:0] COUNT_RST      = 8'h00;  // count byte reset value
  // run register bit positions
  localparam int OVF_B_BIT = 7;
  localparam int RUN_B_BIT = 6;
  localparam int OVF_A_BIT = 5;
  localparam int RUN_A_BIT = 4;
  // mode register field positions, timer a at 0, timer b at 4
  localparam int MODE_B_BASE = 4;
  localparam int MODE_A_BASE = 0;
  localparam int QUAL_OFS    = 3;
  localparam int SRC_OFS     = 2;
  localparam int MSEL_OFS    = 0;
  // cycle counts
  localparam int MACHINE_CYCLE_CLKS = 12;  // processor clocks per machine cycle
  localparam int EDGE_DETECT_MCYC   = 2;   // machine cycles to see a falling edge
  localparam logic [3:0] PRESCALE_LAST = 4'(MACHINE_CYCLE_CLKS - 1);
  // count modes
  typedef enum logic [1:0] {
    DTC_MODE_13 = 2'b00,
    DTC_MODE_16 = 2'b01,
    DTC_MODE_RELOAD = 2'b10,
    DTC_MODE_SPECIAL = 2'b11
  } dtc_mode_t;
endpackage : dtc_pkg

// ==== dtc_prescale.sv ====
// machine cycle tick generator
`timescale 1ns/100ps
module dtc_prescale (
  input  wire logic clock,
  input  wire logic rst_n,
  output logic      mcyc_tick
);
  logic [3:0] cnt_q;  // clock count inside machine cycle
  logic [3:0] cnt_d;  // next count

  // wrap after twelve clocks
  always_comb begin
    cnt_d = (cnt_q == dtc_pkg::PRESCALE_LAST) ? 4'h0 : 4'(cnt_q + 4'h1);
  end

  // register the count
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // one pulse per machine cycle
  assign mcyc_tick = (cnt_q == dtc_pkg::PRESCALE_LAST);

  // tick spacing exactly twelve clocks
  a_tick_period: assert property (@(posedge clock) disable iff (!rst_n)
    mcyc_tick |=> !mcyc_tick [*8] ##1 !mcyc_tick [*3] ##1 mcyc_tick)
    else $error("machine cycle tick not every twelve clocks");
endmodule : dtc_prescale

// ==== dtc_pin_sampler.sv ====
// count pin synchroniser and falling edge detector
`timescale 1ns/100ps
module dtc_pin_sampler (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic pin_raw,
  input  wire logic mcyc_tick,
  output logic      pin_level,
  output logic      fall_seen
);
  logic meta_q;    // first synchroniser stage
  logic sync_q;    // second synchroniser stage
  logic samp_q;    // sample taken at machine cycle
  logic prev_q;    // sample from previous machine cycle
  logic samp_d;
  logic prev_d;

  // sample once per machine cycle; compare two samples
  always_comb begin
    samp_d = mcyc_tick ? sync_q : samp_q;
    prev_d = mcyc_tick ? samp_q : prev_q;
  end

  // registers; idle high so a low pin at reset gives one edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      samp_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
      samp_q <= samp_d;
      prev_q <= prev_d;
    end
  end

  assign pin_level = sync_q;
  // R03: two sample compare
  assign fall_seen = mcyc_tick && prev_q && !samp_q;
endmodule : dtc_pin_sampler

// ==== dtc_top.sv ====
// dual 16-bit timer/counter with register port
`timescale 1ns/100ps
// How it works
// R01: timer mode counts once per twelve clocks
// R02: counter mode counts count pin falling edges
// R03: edge seen over two machine cycle samples
// R04: pin levels held one machine cycle minimum
// R05: two mode bits select four counting modes
// R06: source bit picks pin edges or cycles
// R07: count needs run and pin qualify pass
// R08: 13-bit mode uses high byte, low five
// R09: wrap to zero sets overflow flag
// R10: setting run keeps current count value
// R11: 16-bit mode uses all sixteen bits
// R12: reload mode reloads low from high byte
// R13: timer b special mode holds its count
// R14: timer a special splits into two bytes
// R15: timer b runs unless in special mode
// R16: flags set by hardware, cleared by software
// R17: run bits start and stop timers
// R18: low nibble holds interrupt edge, type bits
// R19: mode 0x89, run 0x88, reset zero
// R20: count bytes writable, write beats increment
module dtc_top (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       count_pin_a,
  input  wire logic       count_pin_b,
  input  wire logic       ext_irq_edge_set_a,
  input  wire logic       ext_irq_edge_set_b,
  input  wire logic       irq_ack_a,
  input  wire logic       irq_ack_b,
  input  wire logic       irq_ack_ext_a,
  input  wire logic       irq_ack_ext_b,
  output logic            overflow_flag_a,
  output logic            overflow_flag_b,
  output logic            ext_irq_edge_flag_a,
  output logic            ext_irq_edge_flag_b,
  output logic            ext_irq_type_a,
  output logic            ext_irq_type_b
);
  logic       mcyc_tick;        // one clock per machine cycle
  logic       pin_a_lvl;        // synchronised pin a
  logic       pin_b_lvl;        // synchronised pin b
  logic       fall_a;           // falling edge on pin a
  logic       fall_b;           // falling edge on pin b
  logic [7:0] run_q;            // run/flag register
  logic [7:0] run_d;
  logic [7:0] mode_q;           // mode register
  logic [7:0] mode_d;
  logic [7:0] low_a_q;          // count bytes
  logic [7:0] low_a_d;
  logic [7:0] high_a_q;
  logic [7:0] high_a_d;
  logic [7:0] low_b_q;
  logic [7:0] low_b_d;
  logic [7:0] high_b_q;
  logic [7:0] high_b_d;
  logic [7:0] rdata_q;          // registered read data
  logic [7:0] rdata_d;
  logic       inc_a;            // timer a low part increments
  logic       inc_b;            // timer b increments
  logic       inc_ah;           // timer a high byte in split mode
  logic       ovf_a;            // overflow events
  logic       ovf_b;
  logic       ovf_ah;
  dtc_pkg::dtc_mode_t mode_a;   // decoded modes
  dtc_pkg::dtc_mode_t mode_b;

  // machine cycle prescaler
  dtc_prescale u_prescale (
    .clock     (clock),
    .rst_n     (rst_n),
    .mcyc_tick (mcyc_tick)
  );

  // count pin samplers
  dtc_pin_sampler u_pin_a (
    .clock     (clock),
    .rst_n     (rst_n),
    .pin_raw   (count_pin_a),
    .mcyc_tick (mcyc_tick),
    .pin_level (pin_a_lvl),
    .fall_seen (fall_a)
  );

  dtc_pin_sampler u_pin_b (
    .clock     (clock),
    .rst_n     (rst_n),
    .pin_raw   (count_pin_b),
    .mcyc_tick (mcyc_tick),
    .pin_level (pin_b_lvl),
    .fall_seen (fall_b)
  );

  // count enable for one timer from its mode nibble
  function automatic logic count_step(input logic [3:0] nib, input logic run,
                                      input logic lvl, input logic fall, input logic tick);
    logic gate_ok;
    // R07: run and pin qualify
    gate_ok = run && (!nib[dtc_pkg::QUAL_OFS] || lvl);
    // R06: pick source; R01 ticks, R02 edges
    count_step = gate_ok && (nib[dtc_pkg::SRC_OFS] ? fall : tick);
  endfunction : count_step

  // advance one timer by its mode
  function automatic logic [16:0] advance(input dtc_pkg::dtc_mode_t m,
                                          input logic [7:0] lo, input logic [7:0] hi);
    logic [13:0] v13;
    logic [16:0] v16;
    logic [8:0]  v8;
    v13 = 14'h0000;
    v16 = 17'h00000;
    v8  = 9'h000;
    case (m)
      dtc_pkg::DTC_MODE_13: begin
        // R08: low five bits under high byte
        v13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        advance = {v13[13], v13[12:5], lo[7:5], v13[4:0]};
      end
      dtc_pkg::DTC_MODE_16: begin
        // R11: full sixteen bits
        v16 = {1'b0, hi, lo} + 17'h00001;
        advance = v16;
      end
      dtc_pkg::DTC_MODE_RELOAD: begin
        // R12: low byte reloads from high
        v8 = {1'b0, lo} + 9'h001;
        advance = {v8[8], hi, v8[8] ? hi : v8[7:0]};
      end
      default: begin
        // split mode low byte: 8-bit, no reload
        v8 = {1'b0, lo} + 9'h001;
        advance = {v8[8], hi, v8[7:0]};
      end
    endcase
  endfunction : advance

  // R05: mode field decode
  assign mode_a = dtc_pkg::dtc_mode_t'(mode_q[dtc_pkg::MODE_A_BASE +: 2]);
  assign mode_b = dtc_pkg::dtc_mode_t'(mode_q[dtc_pkg::MODE_B_BASE +: 2]);

  // increment conditions per timer
  always_comb begin
    inc_a  = count_step(mode_q[dtc_pkg::MODE_A_BASE +: 4], run_q[dtc_pkg::RUN_A_BIT],
                        pin_a_lvl, fall_a, mcyc_tick);
    // R13: special mode freezes timer b; R15 else runs
    inc_b  = (mode_b != dtc_pkg::DTC_MODE_SPECIAL) &&
             count_step(mode_q[dtc_pkg::MODE_B_BASE +: 4], run_q[dtc_pkg::RUN_B_BIT],
                        pin_b_lvl, fall_b, mcyc_tick);
    // R14: split high byte on cycles, run b
    inc_ah = (mode_a == dtc_pkg::DTC_MODE_SPECIAL) && run_q[dtc_pkg::RUN_B_BIT] && mcyc_tick;
  end

  // count bytes next state; software writes win
  always_comb begin
    logic [16:0] nxt_a;
    logic [16:0] nxt_b;
    logic [8:0]  nxt_ah;
    nxt_a    = advance(mode_a, low_a_q, high_a_q);
    nxt_b    = advance(mode_b, low_b_q, high_b_q);
    nxt_ah   = {1'b0, high_a_q} + 9'h001;
    low_a_d  = low_a_q;
    high_a_d = high_a_q;
    low_b_d  = low_b_q;
    high_b_d = high_b_q;
    ovf_a    = 1'b0;
    ovf_b    = 1'b0;
    ovf_ah   = 1'b0;
    // R10: counts only change by increment or write
    if (inc_a) begin
      low_a_d = nxt_a[7:0];
      // split mode keeps high byte for its own counter
      if (mode_a != dtc_pkg::DTC_MODE_SPECIAL) begin
        high_a_d = nxt_a[15:8];
      end
      // R09: wrap raises overflow
      ovf_a = nxt_a[16];
    end
    if (inc_ah) begin
      high_a_d = nxt_ah[7:0];
      ovf_ah   = nxt_ah[8];
    end
    if (inc_b) begin
      low_b_d  = nxt_b[7:0];
      high_b_d = nxt_b[15:8];
      ovf_b    = nxt_b[16];
    end
    // R20: write overrides increment
    if (reg_wr) begin
      case (reg_addr)
        dtc_pkg::LOW_A_ADDR:  low_a_d  = reg_wdata;
        dtc_pkg::HIGH_A_ADDR: high_a_d = reg_wdata;
        dtc_pkg::LOW_B_ADDR:  low_b_d  = reg_wdata;
        dtc_pkg::HIGH_B_ADDR: high_b_d = reg_wdata;
        default: ;
      endcase
    end
  end

  // control registers next state
  always_comb begin
    logic set_b;
    run_d  = run_q;
    mode_d = mode_q;
    // R14: split high byte takes flag b
    set_b  = (mode_a == dtc_pkg::DTC_MODE_SPECIAL) ? ovf_ah : ovf_b;
    if (reg_wr && reg_addr == dtc_pkg::MODE_CTRL_ADDR) begin
      mode_d = reg_wdata;
    end
    // R17: run bits are plain software bits
    if (reg_wr && reg_addr == dtc_pkg::RUN_CTRL_ADDR) begin
      run_d = reg_wdata;
    end
    // R16: service clears flags
    if (irq_ack_a) begin
      run_d[dtc_pkg::OVF_A_BIT] = 1'b0;
    end
    if (irq_ack_b) begin
      run_d[dtc_pkg::OVF_B_BIT] = 1'b0;
    end
    // R18: edge flags in the low nibble
    if (irq_ack_ext_a) begin
      run_d[1] = 1'b0;
    end
    if (irq_ack_ext_b) begin
      run_d[3] = 1'b0;
    end
    if (ext_irq_edge_set_a) begin
      run_d[1] = 1'b1;
    end
    if (ext_irq_edge_set_b) begin
      run_d[3] = 1'b1;
    end
    // R16: hardware set beats any clear
    if (ovf_a) begin
      run_d[dtc_pkg::OVF_A_BIT] = 1'b1;
    end
    if (set_b) begin
      run_d[dtc_pkg::OVF_B_BIT] = 1'b1;
    end
  end

  // read mux, data in following cycle
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        dtc_pkg::RUN_CTRL_ADDR:  rdata_d = run_q;
        dtc_pkg::MODE_CTRL_ADDR: rdata_d = mode_q;
        dtc_pkg::LOW_A_ADDR:     rdata_d = low_a_q;
        dtc_pkg::HIGH_A_ADDR:    rdata_d = high_a_q;
        dtc_pkg::LOW_B_ADDR:     rdata_d = low_b_q;
        dtc_pkg::HIGH_B_ADDR:    rdata_d = high_b_q;
        default:                 rdata_d = 8'h00;  // unmapped reads zero
      endcase
    end
  end

  // R19: all registers reset to zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      run_q    <= dtc_pkg::RUN_CTRL_RST;
      mode_q   <= dtc_pkg::MODE_CTRL_RST;
      low_a_q  <= dtc_pkg::COUNT_RST;
      high_a_q <= dtc_pkg::COUNT_RST;
      low_b_q  <= dtc_pkg::COUNT_RST;
      high_b_q <= dtc_pkg::COUNT_RST;
      rdata_q  <= 8'h00;
    end else begin
      run_q    <= run_d;
      mode_q   <= mode_d;
      low_a_q  <= low_a_d;
      high_a_q <= high_a_d;
      low_b_q  <= low_b_d;
      high_b_q <= high_b_d;
      rdata_q  <= rdata_d;
    end
  end

  assign reg_rdata           = rdata_q;
  assign overflow_flag_a     = run_q[dtc_pkg::OVF_A_BIT];
  assign overflow_flag_b     = run_q[dtc_pkg::OVF_B_BIT];
  assign ext_irq_edge_flag_a = run_q[1];
  assign ext_irq_edge_flag_b = run_q[3];
  assign ext_irq_type_a      = run_q[0];
  assign ext_irq_type_b      = run_q[2];

  // named steps for the reload check
  sequence s_reload_wrap;
    inc_a && mode_a == dtc_pkg::DTC_MODE_RELOAD && low_a_q == 8'hff && !reg_wr;
  endsequence

  a_reload_value: assert property (@(posedge clock) disable iff (!rst_n) // R12
    s_reload_wrap |=> low_a_q == $past(high_a_q) && overflow_flag_a)
    else $error("reload mode did not reload low byte");

  a_timer_no_tick: assert property (@(posedge clock) disable iff (!rst_n) // R01
    (!mcyc_tick && !mode_q[dtc_pkg::SRC_OFS] && !reg_wr && mode_a != dtc_pkg::DTC_MODE_SPECIAL)
    |=> $stable(low_a_q))
    else $error("timer a moved off machine cycle");

  a_run_stop: assert property (@(posedge clock) disable iff (!rst_n) // R17
    (!run_q[dtc_pkg::RUN_B_BIT] && !reg_wr) |=> $stable({low_b_q, high_b_q}))
    else $error("timer b moved while stopped");

  a_b_special_hold: assert property (@(posedge clock) disable iff (!rst_n) // R13
    (mode_b == dtc_pkg::DTC_MODE_SPECIAL && !reg_wr) |=> $stable({low_b_q, high_b_q}))
    else $error("timer b moved in special mode");

  a_qualify_low: assert property (@(posedge clock) disable iff (!rst_n) // R07
    (mode_q[dtc_pkg::QUAL_OFS] && !pin_a_lvl && !reg_wr && mode_a != dtc_pkg::DTC_MODE_SPECIAL)
    |=> $stable({low_a_q, high_a_q}))
    else $error("timer a counted with qualify pin low");

  a_wrap_flag: assert property (@(posedge clock) disable iff (!rst_n) // R09
    (inc_b && mode_b == dtc_pkg::DTC_MODE_16 && {high_b_q, low_b_q} == 16'hffff
     && mode_a != dtc_pkg::DTC_MODE_SPECIAL && !reg_wr)
    |=> overflow_flag_b && {high_b_q, low_b_q} == 16'h0000)
    else $error("16-bit wrap did not raise flag b");

  a_split_flag: assert property (@(posedge clock) disable iff (!rst_n) // R14
    (inc_ah && high_a_q == 8'hff) |=> overflow_flag_b)
    else $error("split high byte wrap did not raise flag b");

  a_write_wins: assert property (@(posedge clock) disable iff (!rst_n) // R20
    (reg_wr && reg_addr == dtc_pkg::LOW_B_ADDR) |=> low_b_q == $past(reg_wdata))
    else $error("count byte write lost");

  a_edge_count: assert property (@(posedge clock) disable iff (!rst_n) // R02
    (fall_b && run_q[dtc_pkg::RUN_B_BIT] && mode_q[6] && !mode_q[7]
     && mode_b == dtc_pkg::DTC_MODE_16 && !reg_wr)
    |=> {high_b_q, low_b_q} == 16'($past({high_b_q, low_b_q}) + 16'h0001))
    else $error("pin edge did not count");
endmodule : dtc_top

// ==== dtc_pin_model.sv ====
// count pin source standing in for the user pin bank
`timescale 1ns/100ps
module dtc_pin_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       go,
  input  wire logic [7:0] falls,
  input  wire logic [7:0] half,
  input  wire logic       idle_lvl,
  output logic            pin,
  output logic            busy
);
  logic [7:0] n_q;  // falls still to finish
  logic [7:0] t_q;  // clocks left in this level
  assign busy = (n_q != 8'h00);
  // burst of falling edges, each level held half clocks
  // level held one machine cycle when half is twelve
  always @(posedge clock) begin
    if (!rst_n) begin
      n_q <= 8'h00;
      pin <= idle_lvl;
    end else if (n_q == 8'h00) begin
      // idle: follow the idle level, a go starts with a fall
      pin <= go ? 1'b0 : idle_lvl;
      n_q <= go ? falls : 8'h00;
      t_q <= half;
    end else if (t_q > 8'h01) begin
      t_q <= t_q - 8'h01;
    end else begin
      // level done: toggle, a rise closes one pulse
      pin <= ~pin;
      t_q <= half;
      if (pin == 1'b0) begin
        n_q <= n_q - 8'h01;
      end
    end
  end
endmodule : dtc_pin_model

// ==== test_dual_timer_counter.sv ====
// self-checking bench for the dual timer/counter
`timescale 1ns/100ps
module test_dual_timer_counter;
  localparam logic [7:0] RUN = dtc_pkg::RUN_CTRL_ADDR;   // run/flag register
  localparam logic [7:0] MODE = dtc_pkg::MODE_CTRL_ADDR; // mode register
  localparam logic [7:0] LOA = dtc_pkg::LOW_A_ADDR;      // low byte a, b follows
  localparam logic [7:0] HIA = dtc_pkg::HIGH_A_ADDR;     // high byte a, b follows
  logic       clock, rst_n, reg_wr, reg_rd, go_a, go_b, lvl_b, pin_a, pin_b, busy_a, busy_b;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, runr, modr;
  logic [1:0] eset, ack, acke;  // edge set, overflow ack, edge ack
  logic [5:0] flg;              // flag outputs
  int         miscompares, check_count, seed, i, lo[2], hi[2];
  // stimulus rows: mode, low a, high a, low b, high b, run, machine cycles
  logic [7:0] tab [7][7] = '{
    '{8'h01, 8'hfd, 8'hff, 8'h00, 8'h00, 8'h10, 8'h05},
    '{8'h00, 8'h00, 8'h00, 8'hfe, 8'hff, 8'h40, 8'h03},
    '{8'h22, 8'hfe, 8'hf0, 8'hff, 8'h80, 8'h50, 8'h04},
    '{8'h13, 8'hff, 8'hfe, 8'h00, 8'h00, 8'h50, 8'h02},
    '{8'h33, 8'h00, 8'h00, 8'h12, 8'h34, 8'h50, 8'h02},
    '{8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03},
    '{8'h11, 8'hff, 8'hff, 8'hff, 8'hff, 8'h50, 8'h01}};

  dtc_top dtc_top_i (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .count_pin_a(pin_a), .count_pin_b(pin_b), .ext_irq_edge_set_a(eset[0]),
    .ext_irq_edge_set_b(eset[1]), .irq_ack_a(ack[0]), .irq_ack_b(ack[1]),
    .irq_ack_ext_a(acke[0]), .irq_ack_ext_b(acke[1]), .overflow_flag_a(flg[4]),
    .overflow_flag_b(flg[5]), .ext_irq_edge_flag_a(flg[1]),
    .ext_irq_edge_flag_b(flg[3]), .ext_irq_type_a(flg[0]), .ext_irq_type_b(flg[2]));
  // pin a bursts three falls, pin b two falls and idles at lvl_b as a gate level
  dtc_pin_model dtc_pin_model_i (.clock(clock), .rst_n(rst_n), .go(go_a),
    .falls(8'h03), .half(8'h0c), .idle_lvl(1'b1), .pin(pin_a), .busy(busy_a));
  dtc_pin_model dtc_pin_model_b_i (.clock(clock), .rst_n(rst_n), .go(go_b),
    .falls(8'h02), .half(8'h0c), .idle_lvl(lvl_b), .pin(pin_b), .busy(busy_b));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test

  // register value compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // flag outputs must mirror the run register bits
  task automatic chk_flags();
    chk({2'b00, flg}, {2'b00, runr[7], runr[5], runr[3:0]});
  endtask : chk_flags

  // one-cycle write strobe, a gap edge before the next
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  // read, data looked at only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & m, exp & m);
  endtask : rd

  // one-cycle pulse on ack, edge set or edge ack
  task automatic pls(input int w);
    @(posedge clock);
    if (w == 0) ack <= 2'b11;
    else if (w == 1) eset <= 2'b11;
    else acke <= 2'b11;
    @(posedge clock);
    ack <= 2'b00;
    eset <= 2'b00;
    acke <= 2'b00;
    #1;
  endtask : pls

  // model: one count of timer t in its mode
  function automatic void bump(input int t);
    int m;
    int v;
    m = (modr >> (4 * t)) & 3;
    if (m == 0) begin
      v = hi[t] * 32 + (lo[t] & 31) + 1;
      if (v == 8192) runr[5 + 2 * t] = 1'b1;
      hi[t] = (v >> 5) & 255;
      lo[t] = (lo[t] & 224) | (v & 31);
    end else if (m == 1) begin
      v = (hi[t] * 256 + lo[t] + 1) & 65535;
      if (v == 0) runr[5 + 2 * t] = 1'b1;
      hi[t] = v >> 8;
      lo[t] = v & 255;
    end else if (m == 2) begin
      lo[t] = lo[t] + 1;
      if (lo[t] == 256) runr[5 + 2 * t] = 1'b1;
      if (lo[t] == 256) lo[t] = hi[t];
    end else begin
      lo[t] = (lo[t] + 1) & 255;
      if (lo[t] == 0) runr[5] = 1'b1;
    end
  endfunction : bump

  // model: one machine cycle of both timers
  function automatic void mdl_tick();
    if (runr[4] && !modr[2] && !modr[3]) bump(0);
    if (runr[6] && !modr[6] && (!modr[7] || lvl_b) && modr[5:4] != 2'b11) bump(1);
    // split mode: high a counts cycles on run b, flags b
    if (modr[1:0] == 2'b11 && runr[6]) begin
      hi[0] = (hi[0] + 1) & 255;
      if (hi[0] == 0) runr[7] = 1'b1;
    end
  endfunction : mdl_tick

  task automatic setmode(input logic [7:0] m);
    wr(MODE, m);
    modr = m;
  endtask : setmode

  task automatic ld(input int t, input logic [7:0] l, input logic [7:0] h);
    wr(LOA + 8'(t), l);
    wr(HIA + 8'(t), h);
    lo[t] = l;
    hi[t] = h;
  endtask : ld

  // run bits stand for exactly 12k counting edges, so any tick phase gives k ticks
  task automatic run_for(input logic [7:0] v, input int k);
    wr(RUN, v);
    runr = v;
    repeat (k) mdl_tick();
    repeat (12 * k - 2) @(posedge clock);
    wr(RUN, runr & 8'haf);
    runr = runr & 8'haf;
  endtask : run_for

  // every register and flag against the model, 13-bit upper bits ignored
  task automatic chk_all();
    rd(LOA, 8'(lo[0]), modr[1:0] == 2'b00 ? 8'h1f : 8'hff);
    rd(LOA + 8'h01, 8'(lo[1]), modr[5:4] == 2'b00 ? 8'h1f : 8'hff);
    rd(HIA, 8'(hi[0]), 8'hff);
    rd(HIA + 8'h01, 8'(hi[1]), 8'hff);
    rd(RUN, runr, 8'hff);
    rd(MODE, modr, 8'hff);
    chk_flags();
  endtask : chk_all

  // main sequence
  initial begin
    {rst_n, reg_wr, reg_rd, go_a, go_b, lvl_b, eset, ack, acke} = '0;
    {reg_addr, reg_wdata, runr, modr} = '0;
    lo = '{0, 0};
    hi = '{0, 0};
    seed = 32'h13c9b82e;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    wr(8'h80, 8'hff);
    rd(8'h80, 8'h00, 8'hff);
    chk_all();
    for (i = 0; i < 2; i++) ld(i, 8'($random(seed)), 8'($random(seed)));
    setmode(8'($random(seed)));
    chk_all();
    for (i = 0; i < 7; i++) begin
      setmode(tab[i][0]);
      ld(0, tab[i][1], tab[i][2]);
      ld(1, tab[i][3], tab[i][4]);
      run_for(tab[i][5], int'(tab[i][6]));
      chk_all();
    end
    pls(0);
    runr = runr & 8'h5f;
    chk_flags();
    wr(RUN, 8'ha5);
    runr = 8'ha5;
    #1;
    chk_flags();
    wr(RUN, 8'h05);
    runr = 8'h05;
    pls(1);
    runr = runr | 8'h0a;
    rd(RUN, runr, 8'hff);
    pls(2);
    runr = runr & 8'hf5;
    chk_flags();
    // pin b low blocks timer b, then high lets it count
    setmode(8'h95);
    ld(1, 8'h00, 8'h00);
    run_for(8'h40, 3);
    chk_all();
    @(posedge clock);
    lvl_b <= 1'b1;
    repeat (4) @(posedge clock);
    run_for(8'h40, 3);
    chk_all();
    // pin falls wrap both 16-bit counts; qualify a set, its low phases must not count
    setmode(8'h5d);
    ld(0, 8'hfe, 8'hff);
    ld(1, 8'hff, 8'hff);
    wr(RUN, 8'h50);
    runr = 8'h50;
    @(posedge clock);
    go_a <= 1'b1;
    go_b <= 1'b1;
    @(posedge clock);
    go_a <= 1'b0;
    go_b <= 1'b0;
    #1;
    for (i = 0; i < 200 && (busy_a !== 1'b0 || busy_b !== 1'b0); i++) @(posedge clock);
    if (busy_a !== 1'b0 || busy_b !== 1'b0) begin
      miscompares++;
      finish_test();
    end
    repeat (3 * dtc_pkg::MACHINE_CYCLE_CLKS) @(posedge clock);
    repeat (3) bump(0);
    repeat (2) bump(1);
    #1;
    chk_flags();
    wr(RUN, runr & 8'haf);
    runr = runr & 8'haf;
    chk_all();
    finish_test();
  end
endmodule : test_dual_timer_counter
